//--- rtl/ubg_uart_baud_gen_fifo_irq.v
// Baud rate generator, FIFOs, interrupt identification and line status.
// Assumes rx framer and tx shifter on clk_sys; APB master on clk_sys.
//
// Chosen here: the register offsets and register access over APB.
`include "ubg_regs.vh"

module ubg_uart_baud_gen_fifo_irq #(
  parameter AW = 4,
  parameter PRE_BASE = `UBG_CLK_KHZ / `UBG_BASE_KHZ,
  parameter PRE_230 = `UBG_CLK_KHZ / `UBG_230_KHZ,
  parameter PRE_460 = `UBG_CLK_KHZ / `UBG_460_KHZ
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Receive framer side
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire [2:0] rx_char_err,
  // Transmit shifter side
  input wire tx_shift_ready,
  input wire tx_shift_empty,
  output wire tx_data_valid,
  output reg [7:0] tx_data,
  // Rate and status outputs
  output reg baud_out,
  output reg baud_tick,
  output reg intr_pending,
  output reg [7:0] line_ctrl
);
  localparam DEPTH = 1 << AW;

  // ==========================================
  // APB decode
  wire [3:0] idx = paddr[5:2];
  wire hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (idx != 4'h4) && (idx != 4'h6) &&
    (idx <= `UBG_IDX_HSPD);
  wire acc = psel && penable;
  wire wr = acc && pwrite && hit;
  wire rd = acc && !pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  reg [7:0] ier_q;
  reg [7:0] fcr_q;
  reg [7:0] scr_q;
  reg hspd_q;
  reg [7:0] div_lo_q;
  reg [7:0] div_hi_q;
  wire dl = line_ctrl[`UBG_LCR_ACCESS];
  wire fifo_en = fcr_q[`UBG_FCR_EN];
  wire wr_data = wr && idx == `UBG_IDX_DATA && !dl;
  wire rd_data = rd && idx == `UBG_IDX_DATA && !dl;
  wire wr_div = wr && (idx == `UBG_IDX_DATA || idx == `UBG_IDX_IER) && dl;
  wire wr_fcr = wr && idx == `UBG_IDX_IIR;
  wire rd_iir = rd && idx == `UBG_IDX_IIR;
  wire rd_lsr = rd && idx == `UBG_IDX_LSR;
  wire fcr_flip = wr_fcr && (pwdata[0] != fifo_en);
  wire rx_clr = fcr_flip || (wr_fcr && pwdata[`UBG_FCR_RXRST]);
  wire tx_clr = fcr_flip || (wr_fcr && pwdata[`UBG_FCR_TXRST]);

  always @(posedge clk_sys) begin
    if (srst) begin
      ier_q <= 8'h00;
      fcr_q <= 8'h00;
      scr_q <= 8'h00;
      hspd_q <= 1'b0;
      line_ctrl <= 8'h00;
      div_lo_q <= 8'h00;
      div_hi_q <= 8'h00;
    end else if (wr) begin
      case (idx)
        `UBG_IDX_DATA: begin
          if (dl) begin
            div_lo_q <= pwdata[7:0];
          end
        end
        `UBG_IDX_IER: begin
          if (dl) begin
            div_hi_q <= pwdata[7:0];
          end else begin
            ier_q <= {4'h0, pwdata[3:0]};
          end
        end
        `UBG_IDX_IIR: fcr_q <= {pwdata[7:6], 5'h00, pwdata[0]};
        `UBG_IDX_LCR: line_ctrl <= pwdata[7:0];
        `UBG_IDX_SCR: scr_q <= pwdata[7:0];
        `UBG_IDX_HSPD: hspd_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Rate generator
  wire [15:0] div = {div_hi_q, div_lo_q};
  wire hs230 = hspd_q && div == `UBG_DIV_230K;
  wire hs460 = hspd_q && div == `UBG_DIV_460K;
  wire [7:0] pre_max = hs230 ? PRE_230[7:0] - 8'h01 : hs460 ? PRE_460[7:0] - 8'h01 : PRE_BASE[7:0] - 8'h01;
  // High-speed divisors act as a divide by one of the faster clock
  wire [15:0] eff = (hs230 || hs460) ? 16'h0001 : div;
  // Zero counts as three
  wire [15:0] period = (eff == 16'h0000) ? 16'h0003 : eff;
  reg [7:0] pre_q;
  reg [15:0] cnt_q;
  wire pre_tick = pre_q == 8'h00;
  wire osc = pre_q > {1'b0, pre_max[7:1]};
  wire wrap = cnt_q >= period - 16'h0001;

  always @(posedge clk_sys) begin
    if (srst) begin
      pre_q <= 8'h00;
      cnt_q <= 16'h0000;
      baud_out <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      pre_q <= (pre_q >= pre_max) ? 8'h00 : pre_q + 8'h01;
      baud_tick <= pre_tick && wrap;
      if (wr_div) begin
        cnt_q <= 16'h0000;
      end else if (pre_tick) begin
        cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      end
      if (period == 16'h0001) begin
        baud_out <= ~osc;
      end else if (period == 16'h0002) begin
        baud_out <= cnt_q[0];
      end else begin
        baud_out <= cnt_q >= 16'h0002;
      end
    end
  end

  // ==========================================
  // Character timing in 16x ticks
  wire [3:0] bits = 4'h7 + {2'b00, line_ctrl[1:0]} + {3'b000, line_ctrl[`UBG_LCR_PAR]} +
    {3'b000, line_ctrl[`UBG_LCR_STOP2]};
  wire [9:0] char_ticks = {2'b00, bits, 4'h0};
  wire [11:0] tmo_limit = {char_ticks, 2'b00};
  wire [9:0] tx_delay = char_ticks - 10'd`UBG_OVERSAMPLE;

  // ==========================================
  // Receive FIFO
  reg [10:0] rx_mem [0:DEPTH-1];
  reg [AW-1:0] rx_wp_q;
  reg [AW-1:0] rx_rp_q;
  reg [AW:0] rx_cnt_q;
  reg [AW:0] err_cnt_q;
  wire rx_full = rx_cnt_q == DEPTH[AW:0];
  wire rx_empty = rx_cnt_q == {(AW+1){1'b0}};
  wire rx_push = rx_char_valid && !rx_full;
  wire rx_pop = rd_data && !rx_empty;
  wire [10:0] rx_top = rx_mem[rx_rp_q];
  wire push_err = rx_push && (rx_char_err != 3'b000);
  wire pop_err = rx_pop && (rx_top[10:8] != 3'b000);

  always @(posedge clk_sys) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= {rx_char_err, rx_char_data};
    end
  end

  always @(posedge clk_sys) begin
    if (srst || rx_clr) begin
      rx_wp_q <= {AW{1'b0}};
      rx_rp_q <= {AW{1'b0}};
      rx_cnt_q <= {(AW+1){1'b0}};
      err_cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      rx_cnt_q <= rx_cnt_q + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
      err_cnt_q <= err_cnt_q + {{AW{1'b0}}, push_err} - {{AW{1'b0}}, pop_err};
    end
  end

  // Trigger levels 1, 4, 8, 14
  reg [AW:0] trig;
  always @* begin
    case (fcr_q[7:6])
      2'b00: trig = 5'd1;
      2'b01: trig = 5'd4;
      2'b10: trig = 5'd8;
      default: trig = 5'd14;
    endcase
  end

  // ==========================================
  // Line status errors, sticky until status read
  reg [3:0] lerr_q;
  wire ovr_evt = rx_char_valid && rx_full;
  wire [2:0] top_err = rx_empty ? 3'b000 : rx_top[10:8];
  always @(posedge clk_sys) begin
    if (srst) begin
      lerr_q <= 4'h0;
    end else begin
      // Set beats the clear of a status read
      lerr_q <= (rd_lsr ? 4'h0 : lerr_q) | {top_err, ovr_evt};
    end
  end

  // ==========================================
  // Receive timeout
  reg [11:0] tmo_q;
  reg tmo_flag_q;
  always @(posedge clk_sys) begin
    if (srst || rx_clr) begin
      tmo_q <= 12'h000;
      tmo_flag_q <= 1'b0;
    end else begin
      if (rx_pop || rx_push || rx_empty) begin
        tmo_q <= 12'h000;
      end else if (baud_tick && tmo_q < tmo_limit) begin
        tmo_q <= tmo_q + 12'h001;
      end
      if (!rx_empty && tmo_q >= tmo_limit && !rx_pop) begin
        tmo_flag_q <= 1'b1;
      end else if (rx_pop || rx_empty) begin
        tmo_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Transmit FIFO
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [AW-1:0] tx_wp_q;
  reg [AW-1:0] tx_rp_q;
  reg [AW:0] tx_cnt_q;
  wire tx_empty = tx_cnt_q == {(AW+1){1'b0}};
  wire tx_full = tx_cnt_q == DEPTH[AW:0];
  wire tx_push = wr_data && !tx_full;
  wire tx_pop = tx_shift_ready && !tx_empty;
  assign tx_data_valid = !tx_empty;

  always @(posedge clk_sys) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= pwdata[7:0];
    end
  end

  always @(posedge clk_sys) begin
    if (srst || tx_clr) begin
      tx_wp_q <= {AW{1'b0}};
      tx_rp_q <= {AW{1'b0}};
      tx_cnt_q <= {(AW+1){1'b0}};
      tx_data <= 8'h00;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      tx_cnt_q <= tx_cnt_q + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
      tx_data <= tx_mem[tx_empty ? tx_wp_q : tx_rp_q];
    end
  end

  // ==========================================
  // Holding-empty indication with single-byte delay
  reg tx_holding_empty_q;
  reg two_seen_q;
  reg [9:0] dly_q;
  reg dly_run_q;
  reg tx_empty_q;
  wire tx_went_empty = tx_empty && !tx_empty_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      tx_holding_empty_q <= 1'b1;
      two_seen_q <= 1'b0;
      dly_q <= 10'h000;
      dly_run_q <= 1'b0;
      tx_empty_q <= 1'b1;
    end else begin
      tx_empty_q <= tx_empty;
      if (tx_holding_empty_q) begin
        two_seen_q <= 1'b0;
      end else if (tx_cnt_q >= 5'd2) begin
        two_seen_q <= 1'b1;
      end
      // A lone byte leaves no time to refill; hold the empty report back
      if (tx_went_empty && fifo_en && !two_seen_q) begin
        dly_q <= 10'h000;
        dly_run_q <= 1'b1;
      end else if (dly_run_q && baud_tick) begin
        dly_q <= dly_q + 10'h001;
        if (dly_q + 10'h001 >= tx_delay) begin
          dly_run_q <= 1'b0;
        end
      end
      if (tx_push) begin
        tx_holding_empty_q <= 1'b0;
      end else if (tx_empty && !dly_run_q && !(tx_went_empty && fifo_en && !two_seen_q)) begin
        tx_holding_empty_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // Transmit interrupt latch
  reg tx_holding_empty_int_q;
  reg ier1_q;
  reg tx_holding_empty_prev_q;
  wire tx_holding_empty_rise = tx_holding_empty_q && !tx_holding_empty_prev_q;
  wire tx_holding_empty_set = tx_holding_empty_rise || (fcr_flip && tx_holding_empty_q) || (ier_q[1] && !ier1_q && tx_holding_empty_q);
  wire [3:0] code;
  wire tx_holding_empty_ack = tx_push || (rd_iir && code == `UBG_IIR_TX_HOLDING_EMPTY);
  always @(posedge clk_sys) begin
    if (srst) begin
      tx_holding_empty_int_q <= 1'b0;
      ier1_q <= 1'b0;
      tx_holding_empty_prev_q <= 1'b1;
    end else begin
      ier1_q <= ier_q[1];
      tx_holding_empty_prev_q <= tx_holding_empty_q;
      // Fresh empty event survives a same-cycle ident read
      if (tx_holding_empty_set) begin
        tx_holding_empty_int_q <= 1'b1;
      end else if (tx_holding_empty_ack) begin
        tx_holding_empty_int_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Interrupt identification
  wire rls_act = ier_q[2] && (lerr_q != 4'h0);
  wire rda_act = ier_q[0] && (fifo_en ? rx_cnt_q >= trig : !rx_empty);
  wire tmo_act = ier_q[0] && fifo_en && tmo_flag_q;
  wire thr_act = ier_q[1] && tx_holding_empty_int_q && tx_holding_empty_q;
  assign code = rls_act ? `UBG_IIR_RLS :
    rda_act ? `UBG_IIR_RDA :
    tmo_act ? `UBG_IIR_TMO :
    thr_act ? `UBG_IIR_TX_HOLDING_EMPTY : `UBG_IIR_NONE;

  always @(posedge clk_sys) begin
    if (srst) begin
      intr_pending <= 1'b0;
    end else begin
      intr_pending <= code != `UBG_IIR_NONE;
    end
  end

  // ==========================================
  // Read mux
  wire [7:0] line_status_reg = {err_cnt_q != 5'd0,
    tx_holding_empty_q && tx_shift_empty,
    tx_holding_empty_q,
    lerr_q, !rx_empty};
  reg [7:0] rdv;
  always @* begin
    case (idx)
      `UBG_IDX_DATA: rdv = dl ? div_lo_q : rx_top[7:0];
      `UBG_IDX_IER: rdv = dl ? div_hi_q : ier_q;
      `UBG_IDX_IIR: rdv = {fifo_en, fifo_en, 2'b00, code};
      `UBG_IDX_LCR: rdv = line_ctrl;
      `UBG_IDX_LSR: rdv = line_status_reg;
      `UBG_IDX_SCR: rdv = scr_q;
      `UBG_IDX_HSPD: rdv = {7'h00, hspd_q};
      default: rdv = 8'h00;
    endcase
  end

  // Data captured in the setup cycle, stable through the access phase
  always @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= {24'h000000, hit ? rdv : 8'h00};
    end
  end
endmodule

//--- rtl/ubg_regs.vh
// Register indices, field positions, reset values and timing counts.
// Assumes byte address = index * 4 on a 32-bit APB bus.
`ifndef UBG_REGS_VH
`define UBG_REGS_VH
// ==========================================
// Register indices
`define UBG_IDX_DATA 4'h0
`define UBG_IDX_IER 4'h1
`define UBG_IDX_IIR 4'h2
`define UBG_IDX_LCR 4'h3
`define UBG_IDX_LSR 4'h5
`define UBG_IDX_SCR 4'h7
`define UBG_IDX_HSPD 4'h8
// ==========================================
// Fields and codes
`define UBG_LCR_ACCESS 7
`define UBG_LCR_STOP2 2
`define UBG_LCR_PAR 3
`define UBG_FCR_EN 0
`define UBG_FCR_RXRST 1
`define UBG_FCR_TXRST 2
`define UBG_IIR_NONE 4'h1
`define UBG_IIR_RLS 4'h6
`define UBG_IIR_RDA 4'h4
`define UBG_IIR_TMO 4'hc
`define UBG_IIR_TX_HOLDING_EMPTY 4'h2
`define UBG_LSR_RST 8'h60
`define UBG_DIV_230K 16'h8002
`define UBG_DIV_460K 16'h8001
// ==========================================
// Timing
`define UBG_CLK_KHZ 250000
`define UBG_BASE_KHZ 1843
`define UBG_230_KHZ 3686
`define UBG_460_KHZ 7373
`define UBG_TMO_CHARS 4
`define UBG_OVERSAMPLE 16
`endif

//--- test/ubg_assertions.sv
// Port-level checker for the baud, FIFO and interrupt block.
// Assumes it is bound to the top module; one clock domain.
module ubg_chk (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // Outputs
  input wire tx_data_valid,
  input wire baud_out,
  input wire intr_pending,
  input wire [7:0] line_ctrl
);
  wire acc = psel && penable;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ==========================================
  // Bus rules
  ready_now_a: assert property (acc |-> pready)
    else $error("access cycle without ready");
  unmapped_err_a: assert property (acc && paddr[5:2] == 4'h4 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && paddr == 12'h00c |-> !pslverr)
    else $error("mapped access refused");
  rd_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  // ==========================================
  // Register and output relations
  lcr_hold_a: assert property (!(acc && pwrite && paddr[11:2] == 10'h3) |=> $stable(line_ctrl))
    else $error("line control changed without write");
  lcr_load_a: assert property (acc && pwrite && paddr == 12'h00c |=> line_ctrl == $past(pwdata[7:0]))
    else $error("line control not loaded");
  txv_cause_a: assert property ($rose(tx_data_valid) |-> $past(acc && pwrite && paddr == 12'h000))
    else $error("transmit data without holding write");
  reset_out_a: assert property (disable iff (1'b0) srst |=> !intr_pending && !baud_out && !tx_data_valid)
    else $error("outputs active after reset");
endmodule

//--- test/ubg_line_model.sv
// Far-side model: receive framer and transmit shifter of the serial line.
// Assumes the bench calls send and sets stall (2 or more) between transfers.
module ubg_line_model (
  // Clock
  input wire clk_sys,
  // Receive framer side
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic [2:0] rx_char_err,
  // Transmit shifter side
  output logic tx_shift_ready,
  output logic tx_shift_empty,
  input wire tx_data_valid,
  input wire [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int stall = 2;
  int n = 0;
  int b = 0;
  logic [7:0] popq[$];
  initial begin
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    rx_char_err = 3'h0;
    tx_shift_ready = 1'b0;
    tx_shift_empty = 1'b1;
  end
  // Data lines go to the inverse once the pulse ends
  task automatic send(input [7:0] d, input [2:0] e);
    @(posedge clk_sys);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_char_err <= e;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~d;
    rx_char_err <= ~e;
  endtask
  // Stall keeps the pop clear of the head update after a push
  always @(posedge clk_sys) begin
    tx_shift_ready <= (n == 1);
    if (tx_shift_ready) begin
      popq.push_back(tx_data);
      b <= 40;
      tx_shift_empty <= 1'b0;
    end else if (b == 1)
      tx_shift_empty <= 1'b1;
    if (b > 0 && !tx_shift_ready)
      b <= b - 1;
    if (n > 0)
      n <= n - 1;
    else if (tx_data_valid === 1'b1 && !tx_shift_ready)
      n <= stall;
  end
endmodule

//--- test/ubg_uart_baud_gen_fifo_irq_bench.sv
// Self-checking bench for the baud, FIFO and interrupt block.
// Assumes the line model on the far side and the checker bound below.
module ubg_uart_baud_gen_fifo_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PB = 4;
  localparam int P23 = 6;
  localparam int P46 = 3;
  logic clk_sys = 0;
  logic srst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire pready, pslverr, tx_data_valid, baud_out, baud_tick, intr_pending;
  wire rx_char_valid, tx_shift_ready, tx_shift_empty;
  wire [31:0] prdata;
  wire [7:0] tx_data, line_ctrl, rx_char_data;
  wire [2:0] rx_char_err;
  int failures = 0;
  int checks_done = 0;
  int tk, per, lo, el;
  int dv[7] = '{0, 1, 2, 3, 0, 32770, 32769};
  logic [7:0] rq, r;
  logic re;
  logic [7:0] exq[$];
  always #2 clk_sys = ~clk_sys;
  ubg_uart_baud_gen_fifo_irq #(.PRE_BASE(PB), .PRE_230(P23), .PRE_460(P46)) dut (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .rx_char_err(rx_char_err),
    .tx_shift_ready(tx_shift_ready), .tx_shift_empty(tx_shift_empty),
    .tx_data_valid(tx_data_valid), .tx_data(tx_data), .baud_out(baud_out),
    .baud_tick(baud_tick), .intr_pending(intr_pending), .line_ctrl(line_ctrl));
  ubg_line_model line (.clk_sys(clk_sys), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_char_err(rx_char_err), .tx_shift_ready(tx_shift_ready),
    .tx_shift_empty(tx_shift_empty), .tx_data_valid(tx_data_valid), .tx_data(tx_data));
  // ==========================================
  // Tasks
  task final_report;
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A used-up wait is a mismatch and ends the run
  task automatic give_up(input string nm);
    failures++;
    $display("[FAIL] %s expected answer seen timeout", nm);
    final_report();
  endtask
  task automatic cmp(input string nm, input [7:0] e, input [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input [3:0] a, input [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h00, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      give_up("apb_ready");
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input [3:0] a, input [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input [3:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // Bounded wait; counts sample ticks on the way
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    tk = 0;
    while (intr_pending !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
      if (baud_tick === 1'b1)
        tk++;
    end
    if (intr_pending !== 1'b1)
      give_up("intr_wait");
  endtask
  task automatic wait_pop(input int k);
    int n;
    n = 0;
    while (line.popq.size() < k && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    if (line.popq.size() < k)
      give_up("tx_pop_wait");
  endtask
  task automatic meas();
    int n;
    n = 0;
    per = 0;
    lo = 0;
    while (baud_out !== 1'b0 && n < 900) begin
      @(posedge clk_sys);
      n++;
    end
    while (baud_out !== 1'b1 && n < 900) begin
      @(posedge clk_sys);
      n++;
    end
    do begin
      @(posedge clk_sys);
      per++;
      if (baud_out === 1'b0)
        lo++;
    end while ((lo == 0 || baud_out !== 1'b1) && per < 900);
    if (n >= 900 || per >= 900)
      give_up("baud_wave");
  endtask
  // Both divisor bytes are loaded before the rate is used
  task automatic setdiv(input int d);
    wr(4'h8, {7'h00, d[15]});
    wr(4'h3, 8'h80);
    wr(4'h0, d[7:0]);
    wr(4'h1, d[15:8]);
    rd(4'h1);
    cmp("div_high", d[15:8], rq);
    wr(4'h3, 8'h03);
  endtask
  task automatic snd(input [7:0] d, input [2:0] e);
    exq.push_back(d);
    line.send(d, e);
  endtask
  task automatic pop_rx();
    rd(4'h0);
    cmp("rx_data", exq.pop_front(), rq);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h156e6931));
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(4'h5);
    cmp("lsr_reset", 8'h60, rq);
    rd(4'h2);
    cmp("iir_reset", 8'h01, rq);
    wr(4'h4, 8'h11);
    cmp("unmapped_wr", 8'h01, {7'h00, re});
    r = $urandom;
    wr(4'h7, r);
    rd(4'h7);
    cmp("scratch", r, rq);
    dv[4] = 4 + $urandom % 6;
    foreach (dv[i]) begin
      setdiv(dv[i]);
      meas();
      el = dv[i] == 0 ? 3 * PB : dv[i] == 32770 ? P23 : dv[i] == 32769 ? P46 : dv[i] * PB;
      cmp("period", el[7:0], per[7:0]);
      el = dv[i] == 2 ? PB : 2 * PB;
      if (dv[i] >= 2 && dv[i] < 10)
        cmp("low_time", el[7:0], lo[7:0]);
    end
    setdiv(1);
    wr(4'h2, 8'h01);
    wr(4'h1, 8'h05);
    snd($urandom, 3'h0);
    wait_irq(20);
    rd(4'h2);
    cmp("iir_data", 8'hc4, rq);
    pop_rx();
    rd(4'h5);
    cmp("lsr_empty", 8'h60, rq);
    wr(4'h2, 8'h41);
    repeat (4) snd($urandom, 3'h0);
    rd(4'h2);
    cmp("iir_trig", 8'hc4, rq);
    pop_rx();
    rd(4'h2);
    cmp("iir_below", 8'hc1, rq);
    wait_irq(4000);
    cmp("tmo_span", 8'h01, {7'h00, tk >= 638 && tk <= 660});
    rd(4'h2);
    cmp("iir_tmo", 8'hcc, rq);
    pop_rx();
    rd(4'h2);
    cmp("tmo_clear", 8'hc1, rq);
    repeat (2) pop_rx();
    wr(4'h2, 8'h01);
    snd(8'h00, 3'h4);
    wait_irq(20);
    rd(4'h2);
    cmp("iir_prio", 8'hc6, rq);
    pop_rx();
    rd(4'h5);
    cmp("lsr_break", 8'h70, rq);
    rd(4'h5);
    cmp("lsr_clear", 8'h60, rq);
    wr(4'h1, 8'h00);
    repeat (2) snd($urandom, 3'h0);
    repeat (3000) @(posedge clk_sys);
    cmp("polled_irq", 8'h00, {7'h00, intr_pending});
    rd(4'h5);
    cmp("polled_lsr", 8'h61, rq);
    repeat (2) pop_rx();
    wr(4'h1, 8'h02);
    wait_irq(20);
    rd(4'h2);
    cmp("iir_tx_holding_empty", 8'hc2, rq);
    rd(4'h2);
    cmp("iir_ack", 8'hc1, rq);
    wr(4'h0, 8'ha5);
    wr(4'h0, 8'h3c);
    wait_pop(2);
    wait_irq(100);
    cmp("tx_first", 8'ha5, line.popq[0]);
    cmp("tx_second", 8'h3c, line.popq[1]);
    line.stall = 9;
    wr(4'h0, 8'h77);
    // Pending output is registered one cycle behind the cause
    @(posedge clk_sys);
    cmp("thr_clear", 8'h00, {7'h00, intr_pending});
    wait_pop(3);
    rd(4'h5);
    cmp("lsr_delay", 8'h00, rq);
    wait_irq(2000);
    rd(4'h5);
    cmp("lsr_tx_idle", 8'h60, rq);
    final_report();
  end
endmodule
bind ubg_uart_baud_gen_fifo_irq ubg_chk chk (.clk_sys(clk_sys), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .tx_data_valid(tx_data_valid), .baud_out(baud_out),
  .intr_pending(intr_pending), .line_ctrl(line_ctrl));
